/* design/scs_channel_status.sv */
// Serial channel control, sync character and line status logic.
`timescale 1ns/10ps
module scs_channel_status
  import scs_pkg::*;
#(
  parameter logic CHANNEL_A = 1'b1
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst_b,
  input  wire logic          i_rx_clock,
  input  wire scs_host_req_t i_host,
  input  wire logic          i_rx_char_avail,
  input  wire logic          i_int_pending,
  input  wire logic [7:0]    i_special_status,
  input  wire logic [7:0]    i_vector,
  input  wire logic [7:0]    i_rx_char,
  input  wire logic          i_break_det,
  input  wire logic          i_tx_underrun,
  input  wire logic          i_crc_sending,
  input  wire logic          i_tx_bit_tick,
  input  wire logic          i_dcd_b,
  input  wire logic          i_cts_b,
  input  wire logic          i_sync_b,
  input  wire logic          i_rx_data,
  output logic [7:0]         o_rd_data,
  output logic               o_rd_valid,
  output logic               o_rx_pop,
  output logic               o_dtr_b,
  output logic               o_tx_serial,
  output logic               o_sync_b,
  output logic               o_sync_oe_b,
  output logic               o_ext_status_irq
);

  // Host side registers and decode.
  logic [2:0]  pointer;
  logic [7:0]  rx_ctrl;
  logic [7:0]  mode_reg;
  logic [7:0]  tx_ctrl;
  logic [7:0]  tx_sync_char;
  logic [7:0]  rx_sync_char;
  logic        wr_ctrl;
  logic        rd_ctrl;
  logic        wr_data;
  logic        rd_data;
  logic        cmd_write;
  logic        reset_ext_cmd;
  logic        reset_undr_cmd;
  logic        enter_hunt;
  logic        rx_disable;
  scs_mode_t   mode;

  assign wr_ctrl   = i_host.sel & i_host.wr & i_host.cd;
  assign rd_ctrl   = i_host.sel & i_host.rd & i_host.cd;
  assign wr_data   = i_host.sel & i_host.wr & ~i_host.cd;
  assign rd_data   = i_host.sel & i_host.rd & ~i_host.cd;
  assign cmd_write = wr_ctrl & (pointer == PTR_STATUS);
  assign reset_ext_cmd =
    cmd_write & (i_host.data[CMD_FIELD_MSB:CMD_FIELD_LSB] == CMD_RESET_EXT);
  assign reset_undr_cmd =
    cmd_write & (i_host.data[CMD_CODE_MSB:CMD_CODE_LSB] == CODE_RESET_UNDR);
  assign enter_hunt = wr_ctrl & (pointer == PTR_RX_CTRL)
                      & i_host.data[ENTER_HUNT_BIT];
  assign rx_disable = wr_ctrl & (pointer == PTR_RX_CTRL)
                      & rx_ctrl[RX_ENABLE_BIT] & ~i_host.data[RX_ENABLE_BIT];

  // A write at the status pointer loads the pointer; any other control port
  // access returns it to the status register so the next access is the default.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pointer <= PTR_STATUS;
    end else if (cmd_write) begin
      pointer <= i_host.data[CMD_PTR_MSB:0];
    end else if (wr_ctrl || rd_ctrl) begin
      pointer <= PTR_STATUS;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_ctrl      <= RST_REG;
      mode_reg     <= RST_REG;
      tx_ctrl      <= RST_REG;
      tx_sync_char <= RST_REG;
      rx_sync_char <= RST_REG;
    end else if (wr_ctrl) begin
      unique case (pointer)
        PTR_RX_CTRL: rx_ctrl      <= i_host.data;
        PTR_MODE:    mode_reg     <= i_host.data;
        PTR_TX_CTRL: tx_ctrl      <= i_host.data;
        PTR_TX_SYNC: tx_sync_char <= i_host.data;
        PTR_RX_SYNC: rx_sync_char <= i_host.data;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    mode = SCS_ASYNC;
    if (mode_reg[STOP_MSB:STOP_LSB] == STOP_SYNC) begin
      unique case (mode_reg[SYNC_MODE_MSB:SYNC_MODE_LSB])
        SYNC_MONO:   mode = SCS_MONO;
        SYNC_BISYNC: mode = SCS_BISYNC;
        SYNC_SDLC:   mode = SCS_SDLC;
        SYNC_EXT:    mode = SCS_EXT;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dtr_b <= RST_LINE_IDLE;
    end else begin
      o_dtr_b <= ~tx_ctrl[DTR_BIT];
    end
  end

  // Pin inputs pass two flops; the first stage is read by nothing else.
  logic [2:0] pin_meta;
  logic [2:0] pin_now;
  logic       sync_prev;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_meta  <= 3'h7;
      pin_now   <= 3'h7;
      sync_prev <= 1'b1;
    end else begin
      pin_meta  <= {i_sync_b, i_cts_b, i_dcd_b};
      pin_now   <= pin_meta;
      sync_prev <= pin_now[2];
    end
  end

  // Transmit buffer and data shifter.
  logic [7:0] tx_buf;
  logic       tx_empty;
  logic [7:0] tx_shift;
  logic [3:0] tx_left;
  logic       tx_take;

  function automatic logic [3:0] scs_tx_bits(input logic [1:0] len,
                                             input logic [7:0] d);
    logic [3:0] n;
    n = 4'h8;
    unique case (len)
      TX_LEN_7: n = 4'h7;
      TX_LEN_6: n = 4'h6;
      TX_LEN_8: n = 4'h8;
      TX_LEN_FIVE: begin
        // Each leading one above the data shortens the character by a bit.
        if (d[7:4] == 4'hF) begin
          n = 4'h1;
        end else if (d[7:5] == 3'h7) begin
          n = 4'h2;
        end else if (d[7:6] == 2'h3) begin
          n = 4'h3;
        end else if (d[7]) begin
          n = 4'h4;
        end else begin
          n = 4'h5;
        end
      end
    endcase
    return n;
  endfunction : scs_tx_bits

  assign tx_take = ~tx_empty & (tx_left == 4'h0) & tx_ctrl[TX_ENABLE_BIT]
                   & ~i_crc_sending;

  // A load in the same cycle as a take refills the buffer, so the load wins.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_buf   <= RST_REG;
      tx_empty <= RST_TX_EMPTY;
    end else if (wr_data) begin
      tx_buf   <= i_host.data;
      tx_empty <= 1'b0;
    end else if (tx_take) begin
      tx_empty <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_shift    <= RST_REG;
      tx_left     <= 4'h0;
      o_tx_serial <= RST_LINE_IDLE;
    end else if (tx_take) begin
      tx_shift <= tx_buf;
      tx_left  <= scs_tx_bits(tx_ctrl[TX_LEN_MSB:TX_LEN_LSB], tx_buf);
    end else if (i_tx_bit_tick) begin
      if (tx_left != 4'h0) begin
        o_tx_serial <= tx_shift[0];
        tx_shift    <= {1'b0, tx_shift[7:1]};
        tx_left     <= tx_left - 4'h1;
      end else begin
        o_tx_serial <= RST_LINE_IDLE;
      end
    end
  end

  logic underrun;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      underrun <= RST_UNDERRUN;
    end else if (i_tx_underrun) begin
      underrun <= 1'b1;
    end else if (reset_undr_cmd) begin
      underrun <= 1'b0;
    end
  end

  // Crossings to and from the receive clock domain.
  logic        cfg_tgl;
  logic        hunt_tgl;
  logic        found_meta;
  logic        found_sync;
  logic        found_prev;
  logic        found_evt;
  logic        found_tgl;
  scs_rx_cfg_t host_cfg;

  assign host_cfg  = '{mode: mode, first: tx_sync_char, second: rx_sync_char};
  assign found_evt = found_sync ^ found_prev;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_tgl  <= 1'b0;
      hunt_tgl <= 1'b0;
    end else begin
      if (wr_ctrl && (pointer == PTR_MODE || pointer == PTR_TX_SYNC
                      || pointer == PTR_RX_SYNC)) begin
        cfg_tgl <= ~cfg_tgl;
      end
      if (enter_hunt || (rx_disable && mode == SCS_SDLC)) begin
        hunt_tgl <= ~hunt_tgl;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      found_meta <= 1'b0;
      found_sync <= 1'b0;
      found_prev <= 1'b0;
    end else begin
      found_meta <= found_tgl;
      found_sync <= found_meta;
      found_prev <= found_sync;
    end
  end

  // Sync/hunt bit, kept differently in async, external, mono/bisync and SDLC modes.
  logic hunt_bit;
  logic ext_armed;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hunt_bit  <= RST_HUNT;
      ext_armed <= 1'b1;
    end else begin
      unique case (mode)
        SCS_ASYNC: begin
          hunt_bit <= ~pin_now[2];
        end
        SCS_EXT: begin
          if (pin_now[2]) begin
            hunt_bit <= 1'b0;
            if (enter_hunt) begin
              ext_armed <= 1'b1;
            end
          end else if (sync_prev && (ext_armed || enter_hunt)) begin
            hunt_bit  <= 1'b1;
            ext_armed <= 1'b0;
          end else if (enter_hunt) begin
            ext_armed <= 1'b1;
          end
        end
        SCS_MONO, SCS_BISYNC: begin
          if (enter_hunt) begin
            hunt_bit <= 1'b1;
          end else if (found_evt) begin
            hunt_bit <= 1'b0;
          end
        end
        SCS_SDLC: begin
          if (enter_hunt || rx_disable) begin
            hunt_bit <= 1'b1;
          end else if (found_evt) begin
            hunt_bit <= 1'b0;
          end
        end
        default: begin
          hunt_bit <= RST_HUNT;
        end
      endcase
    end
  end

  // The pin is only driven in mono and bisync, low while synchronized.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sync_b    <= RST_LINE_IDLE;
      o_sync_oe_b <= 1'b1;
    end else begin
      o_sync_oe_b <= ~(mode == SCS_MONO || mode == SCS_BISYNC);
      o_sync_b    <= hunt_bit;
    end
  end

  // External/status latch. While set, the snapshot is frozen and new
  // changes wait; once cleared, any difference found relatches at once, so
  // a change that lands on the clearing command is never lost.
  scs_ext_t live;
  scs_ext_t snap;
  logic     latched;

  assign live = '{brk: i_break_det, underrun: underrun, cts: ~pin_now[1],
                  hunt: hunt_bit, dcd: ~pin_now[0]};
  assign o_ext_status_irq = latched;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      snap    <= RST_EXT;
      latched <= 1'b0;
    end else if (reset_ext_cmd) begin
      latched <= 1'b0;
    end else if (!latched) begin
      snap <= live;
      if (live != snap) begin
        latched <= 1'b1;
      end
    end
  end

  // Readback never touches a status bit; only the pointer moves.
  logic [7:0] status;

  assign status = {snap.brk, snap.underrun, snap.cts, snap.hunt, snap.dcd,
                   tx_empty,
                   CHANNEL_A & (i_int_pending | latched),
                   i_rx_char_avail};

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_data  <= RST_REG;
      o_rd_valid <= 1'b0;
      o_rx_pop   <= 1'b0;
    end else begin
      o_rd_valid <= rd_ctrl | rd_data;
      o_rx_pop   <= rd_data;
      if (rd_data) begin
        o_rd_data <= i_rx_char;
      end else if (rd_ctrl) begin
        unique case (pointer)
          PTR_STATUS:  o_rd_data <= status;
          PTR_SPECIAL: o_rd_data <= i_special_status;
          PTR_VECTOR:  o_rd_data <= i_vector;
          default:     o_rd_data <= RST_REG;
        endcase
      end
    end
  end

  // Receive clock domain: hunts for the sync pattern in the bit stream.
  // Configuration words are copied only after their toggle has crossed, so
  // the host must leave them alone for a few receive clocks after a write.
  logic        rx_rst_meta;
  logic        rx_rst_b;
  logic        cfg_meta;
  logic        cfg_sync;
  logic        cfg_seen;
  logic        hunt_meta;
  logic        hunt_sync;
  logic        hunt_seen;
  logic        rx_hunting;
  logic [15:0] rx_shift;
  logic        rx_match;
  scs_rx_cfg_t rx_cfg;

  always_ff @(posedge i_rx_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_rst_meta <= 1'b0;
      rx_rst_b    <= 1'b0;
    end else begin
      rx_rst_meta <= 1'b1;
      rx_rst_b    <= rx_rst_meta;
    end
  end

  always_ff @(posedge i_rx_clock or negedge rx_rst_b) begin
    if (!rx_rst_b) begin
      cfg_meta  <= 1'b0;
      cfg_sync  <= 1'b0;
      cfg_seen  <= 1'b0;
      hunt_meta <= 1'b0;
      hunt_sync <= 1'b0;
      hunt_seen <= 1'b0;
      rx_cfg    <= '{mode: SCS_ASYNC, first: RST_REG, second: RST_REG};
    end else begin
      cfg_meta  <= cfg_tgl;
      cfg_sync  <= cfg_meta;
      cfg_seen  <= cfg_sync;
      hunt_meta <= hunt_tgl;
      hunt_sync <= hunt_meta;
      hunt_seen <= hunt_sync;
      if (cfg_sync != cfg_seen) begin
        rx_cfg <= host_cfg;
      end
    end
  end

  always_comb begin
    rx_match = 1'b0;
    unique case (rx_cfg.mode)
      SCS_MONO:   rx_match = (rx_shift[7:0] == rx_cfg.second);
      SCS_BISYNC: rx_match = (rx_shift == {rx_cfg.first, rx_cfg.second});
      SCS_SDLC:   rx_match = (rx_shift[7:0] == rx_cfg.second);
      default:    rx_match = 1'b0;
    endcase
  end

  always_ff @(posedge i_rx_clock or negedge rx_rst_b) begin
    if (!rx_rst_b) begin
      rx_shift   <= 16'h0000;
      rx_hunting <= 1'b1;
      found_tgl  <= 1'b0;
    end else begin
      rx_shift <= {rx_shift[14:0], i_rx_data};
      if (hunt_sync != hunt_seen) begin
        rx_hunting <= 1'b1;
      end else if (rx_hunting && rx_match) begin
        rx_hunting <= 1'b0;
        found_tgl  <= ~found_tgl;
      end
    end
  end

endmodule : scs_channel_status

/* design/scs_pkg.sv */
// Constants and types shared by the serial channel sync and status block.
package scs_pkg;
  // Pointer values that select a register on the control port.
  localparam logic [2:0] PTR_STATUS      = 3'h0;
  localparam logic [2:0] PTR_SPECIAL     = 3'h1;
  localparam logic [2:0] PTR_VECTOR      = 3'h2;
  localparam logic [2:0] PTR_RX_CTRL     = 3'h3;
  localparam logic [2:0] PTR_MODE        = 3'h4;
  localparam logic [2:0] PTR_TX_CTRL     = 3'h5;
  localparam logic [2:0] PTR_TX_SYNC     = 3'h6;
  localparam logic [2:0] PTR_RX_SYNC     = 3'h7;
  // Field positions and command codes of the pointer/command byte.
  localparam int         CMD_PTR_MSB     = 2;
  localparam int         CMD_FIELD_LSB   = 3;
  localparam int         CMD_FIELD_MSB   = 5;
  localparam int         CMD_CODE_LSB    = 6;
  localparam int         CMD_CODE_MSB    = 7;
  localparam logic [2:0] CMD_RESET_EXT   = 3'h2;
  localparam logic [1:0] CODE_RESET_UNDR = 2'h3;
  // Field positions of the receive control, mode and transmit control bytes.
  localparam int         RX_ENABLE_BIT   = 0;
  localparam int         ENTER_HUNT_BIT  = 4;
  localparam int         STOP_LSB        = 2;
  localparam int         STOP_MSB        = 3;
  localparam int         SYNC_MODE_LSB   = 4;
  localparam int         SYNC_MODE_MSB   = 5;
  localparam int         TX_ENABLE_BIT   = 3;
  localparam int         TX_LEN_LSB      = 5;
  localparam int         TX_LEN_MSB      = 6;
  localparam int         DTR_BIT         = 7;
  // Encodings of the stop, sync mode and transmit length fields.
  localparam logic [1:0] STOP_SYNC       = 2'h0;
  localparam logic [1:0] SYNC_MONO       = 2'h0;
  localparam logic [1:0] SYNC_BISYNC     = 2'h1;
  localparam logic [1:0] SYNC_SDLC       = 2'h2;
  localparam logic [1:0] SYNC_EXT        = 2'h3;
  localparam logic [1:0] TX_LEN_FIVE     = 2'h0;
  localparam logic [1:0] TX_LEN_7        = 2'h1;
  localparam logic [1:0] TX_LEN_6        = 2'h2;
  localparam logic [1:0] TX_LEN_8        = 2'h3;
  // Values after reset.
  localparam logic [7:0] RST_REG         = 8'h00;
  localparam logic       RST_TX_EMPTY    = 1'b1;
  localparam logic       RST_UNDERRUN    = 1'b1;
  localparam logic       RST_HUNT        = 1'b1;
  localparam logic       RST_LINE_IDLE   = 1'b1;

  typedef enum logic [2:0] {
    SCS_ASYNC  = 3'h0,
    SCS_MONO   = 3'h1,
    SCS_BISYNC = 3'h3,
    SCS_SDLC   = 3'h2,
    SCS_EXT    = 3'h6
  } scs_mode_t;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic       rd;
    logic       cd;
    logic [7:0] data;
  } scs_host_req_t;

  typedef struct packed {
    logic brk;
    logic underrun;
    logic cts;
    logic hunt;
    logic dcd;
  } scs_ext_t;

  typedef struct packed {
    scs_mode_t  mode;
    logic [7:0] first;
    logic [7:0] second;
  } scs_rx_cfg_t;

  localparam scs_ext_t RST_EXT = '{brk: 1'b0, underrun: RST_UNDERRUN,
                                   cts: 1'b0, hunt: RST_HUNT, dcd: 1'b0};
endpackage : scs_pkg

/* verification/scs_line_model.sv */
// Line-side partner: receive data stream and external sync logic.
`timescale 1ns/10ps
module scs_line_model (
  input  wire logic i_rx_clock,
  output logic      o_rx_data,
  output logic      o_sync_b
);
  logic [15:0] sh = 16'h0000;
  int          left = 0;
  initial o_sync_b = 1'b1;
  initial o_rx_data = 1'b0;
  // Idle bits alternate, so a sync byte of 7E never matches by chance.
  always @(negedge i_rx_clock) begin
    if (left > 0) begin
      o_rx_data <= sh[15];
      sh <= sh << 1;
      left <= left - 1;
    end else begin
      o_rx_data <= ~o_rx_data;
    end
  end
  task automatic frame(input logic [15:0] p, input int n, input logic ext);
    @(posedge i_rx_clock);
    sh = p << (16 - n);
    left = n;
    wait (left == 0);
    @(posedge i_rx_clock);
    if (ext) begin
      repeat (2) @(posedge i_rx_clock);
      o_sync_b = 1'b0;
    end
  endtask : frame
  task automatic pin(input logic v);
    o_sync_b = v;
  endtask : pin
endmodule : scs_line_model

/* verification/scs_props_properties.sv */
// Concurrent checks on the channel status block ports.
`timescale 1ns/10ps
module scs_props
  import scs_pkg::*;
(
  input wire logic          i_clock,
  input wire logic          i_rst_b,
  input wire scs_host_req_t i_host,
  input wire logic          i_int_pending,
  input wire logic [7:0]    i_special_status,
  input wire logic          i_dcd_b,
  input wire logic [7:0]    o_rd_data,
  input wire logic          o_rd_valid,
  input wire logic          o_dtr_b,
  input wire logic          o_ext_status_irq
);
  logic [2:0] ptr;
  wire        wc  = i_host.sel & i_host.wr & i_host.cd;
  wire        rc  = i_host.sel & i_host.rd & i_host.cd;
  wire        clr = wc && ptr == PTR_STATUS &&
                    i_host.data[CMD_FIELD_MSB:CMD_FIELD_LSB] == CMD_RESET_EXT;
  // Mirror of the pointer, so checks know which register a read reaches.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) ptr <= PTR_STATUS;
    else if (wc && ptr == PTR_STATUS) ptr <= i_host.data[CMD_PTR_MSB:0];
    else if (wc || rc) ptr <= PTR_STATUS;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  read_valid_a: assert property (
    o_rd_valid == $past(i_host.sel & i_host.rd)) else $error("valid wrong");
  dtr_follow_a: assert property (wc && ptr == PTR_TX_CTRL |=> ##1
    o_dtr_b == !$past(i_host.data[DTR_BIT], 2)) else $error("dtr wrong");
  special_read_a: assert property (rc && ptr == PTR_SPECIAL &&
    $stable(i_special_status) |=> o_rd_data == $past(i_special_status))
    else $error("special read wrong");
  unused_read_a: assert property (rc && ptr >= PTR_RX_CTRL |=>
    o_rd_data == 8'h00) else $error("unused read not zero");
  int_bit_a: assert property (rc && ptr == PTR_STATUS && i_int_pending &&
    $past(i_int_pending) |=> o_rd_data[1]) else $error("int bit low");
  irq_keep_a: assert property (o_ext_status_irq && !clr |=>
    o_ext_status_irq) else $error("irq dropped");
  irq_clear_a: assert property (clr |=> !o_ext_status_irq)
    else $error("irq not cleared");
  dcd_irq_a: assert property ($fell(i_dcd_b) && !o_ext_status_irq |->
    ##[1:6] o_ext_status_irq) else $error("no irq on carrier");
  cover property (clr && o_ext_status_irq);
  cover property (rc && ptr == PTR_SPECIAL);
  cover property (wc && ptr == PTR_TX_CTRL);
endmodule : scs_props
bind scs_channel_status scs_props i_props (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_host(i_host),
  .i_int_pending(i_int_pending), .i_special_status(i_special_status),
  .i_dcd_b(i_dcd_b), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
  .o_dtr_b(o_dtr_b), .o_ext_status_irq(o_ext_status_irq)
);

/* verification/tb_scs_channel_status.sv */
// Self-checking bench for the channel sync and status block.
`timescale 1ns/10ps
module tb_scs_channel_status
  import scs_pkg::*;
;
  logic          i_clock = 1'b0, i_rx_clock = 1'b0, i_rst_b = 1'b0;
  scs_host_req_t i_host = '0;
  logic          i_rx_char_avail = 1'b0, i_int_pending = 1'b0;
  logic          i_break_det = 1'b0, i_tx_underrun = 1'b0;
  logic          i_crc_sending = 1'b0, i_tx_bit_tick = 1'b0;
  logic          i_dcd_b = 1'b1, i_cts_b = 1'b1, i_sync_b, i_rx_data, m_sync;
  logic [7:0]    i_special_status = 8'h00, i_vector = 8'h00;
  logic [7:0]    i_rx_char = 8'h00, o_rd_data, rdat, d;
  logic          o_rd_valid, o_rx_pop, o_dtr_b, o_tx_serial, o_sync_b;
  logic          o_sync_oe_b, o_ext_status_irq, rval, dt, rpop;
  logic [1:0]    lcode;
  int            n_errors = 0, checked = 0, cyc = 0;
  // The sync pin is two-way: the device wins only while it enables.
  assign i_sync_b = o_sync_oe_b ? m_sync : o_sync_b;
  always #5 i_clock = ~i_clock;
  initial begin
    #2.3;
    forever #6 i_rx_clock = ~i_rx_clock;
  end
  scs_channel_status i_dut (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_rx_clock(i_rx_clock),
    .i_host(i_host), .i_rx_char_avail(i_rx_char_avail),
    .i_int_pending(i_int_pending), .i_special_status(i_special_status),
    .i_vector(i_vector), .i_rx_char(i_rx_char), .i_break_det(i_break_det),
    .i_tx_underrun(i_tx_underrun), .i_crc_sending(i_crc_sending),
    .i_tx_bit_tick(i_tx_bit_tick), .i_dcd_b(i_dcd_b), .i_cts_b(i_cts_b),
    .i_sync_b(i_sync_b), .i_rx_data(i_rx_data), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_rx_pop(o_rx_pop), .o_dtr_b(o_dtr_b),
    .o_tx_serial(o_tx_serial), .o_sync_b(o_sync_b),
    .o_sync_oe_b(o_sync_oe_b), .o_ext_status_irq(o_ext_status_irq)
  );
  scs_line_model i_line (
    .i_rx_clock(i_rx_clock), .o_rx_data(i_rx_data), .o_sync_b(m_sync)
  );
  task automatic end_of_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk8(input string nm, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk1(input string nm, input logic e, g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask : chk1
  function automatic int nbits(input logic [1:0] lc, input logic [7:0] v);
    case (lc)
      TX_LEN_7: return 7;
      TX_LEN_6: return 6;
      TX_LEN_8: return 8;
      default: return v[7:4] == 4'hF ? 1 : v[7:5] == 3'h7 ? 2 :
                      v[7:6] == 2'h3 ? 3 : v[7] ? 4 : 5;
    endcase
  endfunction : nbits
  task automatic acc(input logic wr, cd, input logic [7:0] v);
    @(negedge i_clock);
    i_host = '{1'b1, wr, !wr, cd, v};
    @(negedge i_clock);
    i_host = '0;
    rdat = o_rd_data;
    rval = o_rd_valid;
    rpop = o_rx_pop;
  endtask : acc
  task automatic wreg(input logic [2:0] p, input logic [7:0] v);
    acc(1'b1, 1'b1, {5'h00, p});
    acc(1'b1, 1'b1, v);
  endtask : wreg
  task automatic rreg(input logic [2:0] p);
    if (p != PTR_STATUS) acc(1'b1, 1'b1, {5'h00, p});
    acc(1'b0, 1'b1, 8'h00);
    chk1("rd_valid", 1'b1, rval);
    chk1("rx_pop", 1'b0, rpop);
  endtask : rreg
  task automatic stat(input logic [7:0] e, m);
    rreg(PTR_STATUS);
    chk8("status", e & m, rdat & m);
  endtask : stat
  // Two clears, because a clear relatches whatever changed meanwhile.
  task automatic clr();
    repeat (2) begin
      repeat (6) @(negedge i_clock);
      acc(1'b1, 1'b1, {2'h0, CMD_RESET_EXT, PTR_STATUS});
    end
    repeat (6) @(negedge i_clock);
  endtask : clr
  task automatic wirq();
    for (int i = 0; i < 30 && o_ext_status_irq !== 1'b1; i++)
      @(negedge i_clock);
    chk1("ext_irq", 1'b1, o_ext_status_irq);
  endtask : wirq
  task automatic txbits(input logic [7:0] v, input int n);
    for (int i = 0; i <= n; i++) begin
      @(negedge i_clock);
      i_tx_bit_tick = 1'b1;
      @(negedge i_clock);
      i_tx_bit_tick = 1'b0;
      chk1("tx_serial", i < n ? v[i] : 1'b1, o_tx_serial);
    end
  endtask : txbits
  initial begin
    void'($urandom(32'h1049));
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    i_rst_b = 1'b1;
    repeat (8) @(negedge i_clock);
    chk1("dtr_b", 1'b1, o_dtr_b);
    stat(8'h54, 8'hFF);
    i_crc_sending = 1'b1;
    wreg(PTR_TX_CTRL, 8'h68);
    acc(1'b1, 1'b0, 8'hA5);
    repeat (3) @(negedge i_clock);
    stat(8'h00, 8'h04);
    i_crc_sending = 1'b0;
    repeat (3) @(negedge i_clock);
    stat(8'h04, 8'h04);
    txbits(8'hA5, 8);
    for (int k = 0; k < 8; k++) begin
      lcode = k < 5 ? TX_LEN_FIVE : k == 5 ? TX_LEN_6 :
              k == 6 ? TX_LEN_7 : TX_LEN_8;
      dt = 1'($urandom);
      d = (8'hFF << (k + 4)) | (8'($urandom) & ~(8'hFF << (k + 1)));
      wreg(PTR_TX_CTRL, {dt, lcode, 1'b0, 1'b1, 3'h0});
      acc(1'b1, 1'b0, d);
      chk1("dtr_b", !dt, o_dtr_b);
      repeat (3) @(negedge i_clock);
      txbits(d, nbits(lcode, d));
    end
    i_special_status = 8'($urandom);
    i_vector = 8'($urandom);
    i_rx_char = 8'($urandom);
    i_int_pending = 1'b1;
    i_rx_char_avail = 1'b1;
    rreg(PTR_SPECIAL);
    chk8("special", i_special_status, rdat);
    rreg(PTR_VECTOR);
    chk8("vector", i_vector, rdat);
    rreg(PTR_MODE);
    chk8("unused", 8'h00, rdat);
    wreg(PTR_SPECIAL, 8'hFF);
    stat(8'h03, 8'h03);
    stat(8'h03, 8'h03);
    acc(1'b0, 1'b0, 8'h00);
    chk8("rx_char", i_rx_char, rdat);
    chk1("rx_pop", 1'b1, rpop);
    i_int_pending = 1'b0;
    i_rx_char_avail = 1'b0;
    stat(8'h00, 8'h03);
    i_dcd_b = 1'b0;
    wirq();
    stat(8'h08, 8'h28);
    i_cts_b = 1'b0;
    repeat (8) @(negedge i_clock);
    stat(8'h08, 8'h28);
    acc(1'b1, 1'b1, 8'h10);
    wirq();
    stat(8'h28, 8'h28);
    i_break_det = 1'b1;
    clr();
    stat(8'hA8, 8'hA8);
    i_break_det = 1'b0;
    i_dcd_b = 1'b1;
    i_cts_b = 1'b1;
    clr();
    stat(8'h00, 8'hA8);
    acc(1'b1, 1'b1, 8'hC0);
    clr();
    stat(8'h00, 8'h40);
    @(negedge i_clock);
    i_tx_underrun = 1'b1;
    @(negedge i_clock);
    i_tx_underrun = 1'b0;
    wirq();
    stat(8'h40, 8'h40);
    for (int m = 0; m < 4; m++) begin
      wreg(PTR_MODE, {2'h0, 2'(m), 4'h0});
      wreg(PTR_TX_SYNC, 8'hC3);
      wreg(PTR_RX_SYNC, 8'h7E);
      repeat (20) @(negedge i_clock);
      wreg(PTR_RX_CTRL, 8'h11);
      clr();
      stat(m == 3 ? 8'h00 : 8'h10, 8'h10);
      i_line.frame({8'hC3, 8'h7E}, m == 1 ? 16 : 8, m == 3);
      wirq();
      stat(m == 3 ? 8'h10 : 8'h00, 8'h10);
      if (m < 2) chk1("sync_oe_b", 1'b0, o_sync_oe_b);
      if (m < 2) chk1("sync_b", 1'b0, o_sync_b);
      clr();
      i_line.pin(1'b1);
      if (m == 3) wirq();
    end
    wreg(PTR_MODE, 8'h04);
    repeat (20) @(negedge i_clock);
    clr();
    stat(8'h00, 8'h10);
    i_line.pin(1'b0);
    wirq();
    stat(8'h10, 8'h10);
    end_of_test();
  end
endmodule : tb_scs_channel_status
